// File: verilog/bldc_pkg.sv
// shared constants and carrier types for the commutation logic
package bldc_pkg;
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned PWM_FREQ_HZ = 10_500;
  localparam int unsigned RAMP_STEPS = 256;
  localparam int unsigned RAMP_W = 8;
  // ramp step rounded down so one ramp sweep is never longer than the nominal period
  localparam int unsigned PWM_STEP_CYC = CLK_HZ / (PWM_FREQ_HZ * RAMP_STEPS);
  localparam int unsigned STEP_W = 16;
  localparam int unsigned SPEED_PULSE_US = 100;
  localparam int unsigned SPEED_PULSE_CYC = SPEED_PULSE_US * (CLK_HZ / 1_000_000);
  localparam int unsigned PULSE_W = 24;
  localparam int unsigned SYNC_STAGES = 2;
  localparam logic [2:0] SENSOR_ALL_LOW = 3'h0;
  localparam logic [2:0] SENSOR_ALL_HIGH = 3'h7;
  localparam logic [2:0] PH_A = 3'h4;
  localparam logic [2:0] PH_B = 3'h2;
  localparam logic [2:0] PH_C = 3'h1;
  localparam logic [2:0] PH_NONE = 3'h0;

  // bit 2 is phase A, bit 0 is phase C
  typedef struct packed {
    logic [2:0] hs;
    logic [2:0] ls;
  } phase_drive_t;

  typedef struct packed {
    logic tick;
    logic [RAMP_W-1:0] ramp;
  } pwm_time_t;
endpackage

// File: verilog/pwm_timebase.sv
// pwm oscillator: ramp generator and one tick per ramp period
`timescale 1ns/1ps
module pwm_timebase import bldc_pkg::*; #(
  parameter int unsigned STEP_CYC = PWM_STEP_CYC
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  output pwm_time_t time_o
);
  typedef struct packed {
    logic [STEP_W-1:0] step;
    logic [RAMP_W-1:0] ramp;
    logic tick;
  } tb_state_t;

  tb_state_t st_q, st_d;

  always_comb begin
    st_d = st_q;
    st_d.tick = 1'b0;
    if (st_q.step == STEP_W'(STEP_CYC - 1)) begin
      st_d.step = '0;
      st_d.ramp = st_q.ramp + 1'b1;
      // wrap of the ramp marks the start of a new pwm period
      if (st_q.ramp == {RAMP_W{1'b1}}) begin
        st_d.tick = 1'b1;
      end
    end else begin
      st_d.step = st_q.step + 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign time_o.tick = st_q.tick;
  assign time_o.ramp = st_q.ramp;
endmodule // pwm_timebase

// File: verilog/speed_pulse.sv
// retriggerable fixed width pulse stretcher for the speed output
`timescale 1ns/1ps
module speed_pulse import bldc_pkg::*; #(
  parameter int unsigned WIDTH_CYC = SPEED_PULSE_CYC
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic trig_i,
  output logic active_o
);
  typedef struct packed {
    logic [PULSE_W-1:0] cnt;
  } sp_state_t;

  sp_state_t st_q, st_d;

  always_comb begin
    st_d = st_q;
    if (trig_i) begin
      st_d.cnt = PULSE_W'(WIDTH_CYC);
    end else if (st_q.cnt != '0) begin
      st_d.cnt = st_q.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign active_o = (st_q.cnt != '0);
endmodule // speed_pulse

// File: verilog/bldc_commutation_logic.sv
// commutation, rotation dead time, drive gating and speed pulse for a 3-phase bldc driver
`timescale 1ns/1ps
// Functional notes
// - rotation select goes into a holding latch, then a two-stage shift register.
// - any latch or shift stage input/output mismatch forces all phases open.
// - shift register steps on the pwm tick, giving one to two periods dead time.
// - pwm oscillator runs at a typical 10.5 kHz.
// - every position-sensor change fires a retriggerable high pulse on the speed output.
// - speed pulse width is a fixed constant, taken here as 100 us.
// - phase source, sink or open is decoded from sensors and delayed rotation.
// - an undriven position-sensor input reads as logic high.
// - enable input is the master permit for driving the phases.
// - no phase drive until the sensor supply reference is in regulation.
// - peak or overcurrent trip blocks drive for the rest of that pwm cycle.
// - duty cycle comes from comparing current error against the pwm ramp.
// - truth table maps the six legal sensor codes per rotation to phase states.
// - sensor codes all-low or all-high are illegal and open all phases.
module bldc_commutation_logic import bldc_pkg::*; #(
  parameter int unsigned STEP_CYC = PWM_STEP_CYC,
  parameter int unsigned PULSE_CYC = SPEED_PULSE_CYC
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [2:0] sensor_i,
  input wire logic [2:0] sensor_oe_i,
  input wire logic rotation_i,
  input wire logic enable_i,
  input wire logic sensor_supply_ref_ok_i,
  input wire logic peak_limit_i,
  input wire logic over_current_i,
  input wire logic [RAMP_W-1:0] current_error_i,
  output phase_drive_t drive_o,
  output logic speed_o
);
  typedef struct packed {
    logic [2:0] sens_s1;
    logic [2:0] sens_s2;
    logic [2:0] sens_prev;
    logic rot_s1;
    logic rot_s2;
    logic rot_latch;
    logic [1:0] rot_sr;
    logic limit;
    phase_drive_t drive;
    logic speed;
    // check-only counters for the assertions; nothing in the datapath reads them
    logic [PULSE_W-1:0] pulse_age;
    logic [31:0] tick_gap;
  } cl_state_t;
  // sensor stages leave reset at the pulled-up idle level, so reset alone is no edge
  localparam cl_state_t CL_RESET = '{sens_s1: SENSOR_ALL_HIGH, sens_s2: SENSOR_ALL_HIGH,
                                     sens_prev: SENSOR_ALL_HIGH, default: '0};
  localparam logic [31:0] PWM_PERIOD_CYC = 32'(RAMP_STEPS * STEP_CYC);
  localparam logic [PULSE_W-1:0] SPEED_AGE_AT_FALL = PULSE_W'(PULSE_CYC);

  cl_state_t st_q, st_d;
  pwm_time_t pwm_time;
  logic pulse_active;
  logic sensor_edge;
  logic rot_inhibit;
  logic code_illegal;
  logic pwm_on;
  logic drive_allowed;
  phase_drive_t decoded;

  // hs bit set = phase sources, ls bit set = phase sinks, neither = open
  function automatic phase_drive_t decode_phase(input logic rot, input logic [2:0] code);
    phase_drive_t d;
    d = '{hs: PH_NONE, ls: PH_NONE};
    if (rot) begin
      unique case (code)
        3'h1: d = '{hs: PH_C, ls: PH_B};
        3'h3: d = '{hs: PH_C, ls: PH_A};
        3'h2: d = '{hs: PH_B, ls: PH_A};
        3'h6: d = '{hs: PH_B, ls: PH_C};
        3'h4: d = '{hs: PH_A, ls: PH_C};
        3'h5: d = '{hs: PH_A, ls: PH_B};
        default: d = '{hs: PH_NONE, ls: PH_NONE};
      endcase
    end else begin
      unique case (code)
        3'h5: d = '{hs: PH_B, ls: PH_A};
        3'h4: d = '{hs: PH_C, ls: PH_A};
        3'h6: d = '{hs: PH_C, ls: PH_B};
        3'h2: d = '{hs: PH_A, ls: PH_B};
        3'h3: d = '{hs: PH_A, ls: PH_C};
        3'h1: d = '{hs: PH_B, ls: PH_C};
        default: d = '{hs: PH_NONE, ls: PH_NONE};
      endcase
    end
    return d;
  endfunction

  pwm_timebase #(
    .STEP_CYC(STEP_CYC)
  ) u_timebase (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .time_o(pwm_time)
  );

  speed_pulse #(
    .WIDTH_CYC(PULSE_CYC)
  ) u_speed (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .trig_i(sensor_edge),
    .active_o(pulse_active)
  );

  // edge detect compares the second stage with sens_prev, never the metastable first one
  assign sensor_edge = (st_q.sens_s2 != st_q.sens_prev);
  assign rot_inhibit = (st_q.rot_s2 != st_q.rot_latch) ||
                       (st_q.rot_latch != st_q.rot_sr[0]) ||
                       (st_q.rot_sr[0] != st_q.rot_sr[1]);
  assign code_illegal = (st_q.sens_s2 == SENSOR_ALL_LOW) ||
                        (st_q.sens_s2 == SENSOR_ALL_HIGH);
  assign pwm_on = (pwm_time.ramp < current_error_i);
  assign decoded = decode_phase(st_q.rot_sr[1], st_q.sens_s2);
  assign drive_allowed = enable_i && sensor_supply_ref_ok_i && !rot_inhibit &&
                         !code_illegal && pwm_on && !st_q.limit &&
                         !peak_limit_i && !over_current_i;

  always_comb begin
    st_d = st_q;
    // pulled-up input: a sensor nobody drives is seen as high
    st_d.sens_s1 = (sensor_i & sensor_oe_i) | ~sensor_oe_i;
    st_d.sens_s2 = st_q.sens_s1;
    st_d.sens_prev = st_q.sens_s2;
    st_d.rot_s1 = rotation_i;
    st_d.rot_s2 = st_q.rot_s1;
    st_d.rot_latch = st_q.rot_s2;
    if (pwm_time.tick) begin
      st_d.rot_sr = {st_q.rot_sr[0], st_q.rot_latch};
    end
    // trip holds to the end of the cycle; a trip in the tick cycle itself wins
    if (peak_limit_i || over_current_i) begin
      st_d.limit = 1'b1;
    end else if (pwm_time.tick) begin
      st_d.limit = 1'b0;
    end
    if (drive_allowed) begin
      st_d.drive = decoded;
    end else begin
      st_d.drive = '{hs: PH_NONE, ls: PH_NONE};
    end
    st_d.speed = pulse_active;
    // age since the last sensor edge saturates, so a stalled motor cannot wrap it
    if (sensor_edge) begin
      st_d.pulse_age = '0;
    end else if (st_q.pulse_age != '1) begin
      st_d.pulse_age = st_q.pulse_age + 1'b1;
    end
    if (pwm_time.tick) begin
      st_d.tick_gap = 32'h1;
    end else begin
      st_d.tick_gap = st_q.tick_gap + 32'h1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q <= CL_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  assign drive_o = st_q.drive;
  assign speed_o = st_q.speed;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence s_phases_open;
    (drive_o.hs == PH_NONE) && (drive_o.ls == PH_NONE);
  endsequence

  sequence s_sensor_moved;
    sensor_edge;
  endsequence

  sequence s_pulse_follows;
    ##2 speed_o;
  endsequence

  sequence s_current_trip;
    peak_limit_i || over_current_i;
  endsequence

  sequence s_period_end;
    pwm_time.tick;
  endsequence

  // restates the truth table phase by phase, independent of decode_phase
  property p_table(logic rot, logic [2:0] code, logic [5:0] exp_drive);
    (drive_allowed && (st_q.rot_sr[1] == rot) && (st_q.sens_s2 == code))
      |=> (drive_o == exp_drive);
  endproperty

  AST_ENABLE_OFF: assert property (!enable_i |=> s_phases_open)
    else $error("phase driven while enable inactive");

  AST_BOTH_SWITCHES_OFF: assert property ((drive_o.hs & drive_o.ls) == PH_NONE)
    else $error("high and low switch on together");

  AST_SUPPLY_GATE: assert property (!sensor_supply_ref_ok_i |=> s_phases_open)
    else $error("phase driven before sensor supply regulated");

  AST_ROT_INHIBIT: assert property (rot_inhibit |=> s_phases_open)
    else $error("phase driven during rotation change");

  AST_ILLEGAL_CODE: assert property (code_illegal |=> s_phases_open)
    else $error("phase driven on illegal sensor code");

  AST_LIMIT_HOLD: assert property ((peak_limit_i || over_current_i) && !pwm_time.tick
                                   |=> s_phases_open ##1 s_phases_open)
    else $error("drive not blocked after current trip");

  AST_DUTY_OFF: assert property (!pwm_on |=> s_phases_open)
    else $error("phase driven while ramp above error");

  AST_SPEED_PULSE: assert property (s_sensor_moved |-> s_pulse_follows)
    else $error("no speed pulse after sensor change");

  AST_DEAD_TIME: assert property ($changed(st_q.rot_sr[1]) |-> $past(pwm_time.tick))
    else $error("rotation reached decoder off the pwm tick");

  AST_DECODE: assert property (drive_allowed |=> drive_o == $past(decoded))
    else $error("phase drive differs from decoded state");

  AST_TRIP_SET_WINS: assert property (s_current_trip ##0 s_period_end |=> st_q.limit)
    else $error("current trip lost at the period boundary");

  AST_LIMIT_CLEAR: assert property ((st_q.limit && !peak_limit_i && !over_current_i)
                                    ##0 s_period_end |=> !st_q.limit)
    else $error("current limit not released at the period boundary");

  AST_LIMIT_BLOCKS: assert property (st_q.limit |=> s_phases_open)
    else $error("phase driven while current limit held");

  AST_SR_HOLD: assert property (!pwm_time.tick |=> $stable(st_q.rot_sr))
    else $error("rotation shift register moved between pwm ticks");

  AST_ROT_BLANK: assert property ($changed(st_q.rot_s2) |=> s_phases_open ##1 s_phases_open)
    else $error("phase driven right after a rotation change");

  AST_TICK_PERIOD: assert property (pwm_time.tick == (st_q.tick_gap == PWM_PERIOD_CYC))
    else $error("pwm period differs from the ramp length");

  AST_SPEED_CAUSE: assert property ($rose(speed_o) |-> $past(sensor_edge, 2))
    else $error("speed pulse without a sensor change");

  AST_SPEED_WIDTH: assert property ($fell(speed_o) |-> $past(st_q.pulse_age) == SPEED_AGE_AT_FALL)
    else $error("speed pulse width differs from the fixed constant");

  AST_SPEED_RETRIGGER: assert property (speed_o ##0 s_sensor_moved |-> s_pulse_follows ##1 speed_o)
    else $error("speed pulse not retriggered by a sensor change");

  AST_DRIVE_PERMIT: assert property ((drive_o.hs | drive_o.ls) != PH_NONE
                                     |-> $past(enable_i && sensor_supply_ref_ok_i))
    else $error("phase driven without enable and supply permit");

  AST_PULLUP: assert property (sensor_oe_i == 3'h0 |=> st_q.sens_s1 == SENSOR_ALL_HIGH)
    else $error("undriven sensors not read as high");

  AST_FWD_CODE1: assert property (p_table(1'b1, 3'h1, {PH_C, PH_B}))
    else $error("forward code 1 drives the wrong phases");

  AST_FWD_CODE3: assert property (p_table(1'b1, 3'h3, {PH_C, PH_A}))
    else $error("forward code 3 drives the wrong phases");

  AST_FWD_CODE2: assert property (p_table(1'b1, 3'h2, {PH_B, PH_A}))
    else $error("forward code 2 drives the wrong phases");

  AST_FWD_CODE6: assert property (p_table(1'b1, 3'h6, {PH_B, PH_C}))
    else $error("forward code 6 drives the wrong phases");

  AST_FWD_CODE4: assert property (p_table(1'b1, 3'h4, {PH_A, PH_C}))
    else $error("forward code 4 drives the wrong phases");

  AST_FWD_CODE5: assert property (p_table(1'b1, 3'h5, {PH_A, PH_B}))
    else $error("forward code 5 drives the wrong phases");

  AST_REV_CODE5: assert property (p_table(1'b0, 3'h5, {PH_B, PH_A}))
    else $error("reverse code 5 drives the wrong phases");

  AST_REV_CODE4: assert property (p_table(1'b0, 3'h4, {PH_C, PH_A}))
    else $error("reverse code 4 drives the wrong phases");

  AST_REV_CODE6: assert property (p_table(1'b0, 3'h6, {PH_C, PH_B}))
    else $error("reverse code 6 drives the wrong phases");

  AST_REV_CODE2: assert property (p_table(1'b0, 3'h2, {PH_A, PH_B}))
    else $error("reverse code 2 drives the wrong phases");

  AST_REV_CODE3: assert property (p_table(1'b0, 3'h3, {PH_A, PH_C}))
    else $error("reverse code 3 drives the wrong phases");

  AST_REV_CODE1: assert property (p_table(1'b0, 3'h1, {PH_B, PH_C}))
    else $error("reverse code 1 drives the wrong phases");
endmodule // bldc_commutation_logic

// File: tb/hall_model.sv
// gray coded position sensor source standing in for the motor sensors
`timescale 1ns/1ps
module hall_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic adv_i,
  input wire logic float_i,
  input wire logic short_i,
  output logic [2:0] sensor_o,
  output logic [2:0] oe_o
);
  // 120 degree spacing, so no sensor needs inverting here
  logic [2:0] seq [6] = '{3'h1, 3'h3, 3'h2, 3'h6, 3'h4, 3'h5};
  int unsigned idx;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) idx <= 0;
    else if (adv_i) idx <= (idx == 5) ? 0 : idx + 1;
  end
  // a released pin shows the inverse level, so only the pull-up can make it read high
  // a shorted harness drives all three sensors low, the other illegal code
  assign sensor_o = short_i ? 3'h0 : (float_i ? ~seq[idx] : seq[idx]);
  assign oe_o = (float_i && !short_i) ? 3'h0 : 3'h7;
endmodule // hall_model

// File: tb/bldc_commutation_logic_tb.sv
// self-checking bench for the commutation logic
`timescale 1ns/1ps
module bldc_commutation_logic_tb;
  import bldc_pkg::*;
  localparam int unsigned PW = 20;
  logic clk_i, rst_n_i, rotation_i, enable_i, ok_i, peak_i, over_i, adv, flt, shrt, speed_o;
  logic [7:0] err_i;
  logic [2:0] sens, oe;
  phase_drive_t drive_o;
  int err_total, n_checks, idx;
  logic [2:0] seq [6] = '{3'h1, 3'h3, 3'h2, 3'h6, 3'h4, 3'h5};
  always #2 clk_i = ~clk_i;
  hall_model u_hall (.clk_i(clk_i), .rst_n_i(rst_n_i), .adv_i(adv), .float_i(flt),
    .short_i(shrt), .sensor_o(sens), .oe_o(oe));
  bldc_commutation_logic #(.STEP_CYC(1), .PULSE_CYC(PW)) u_dut (.clk_i(clk_i),
    .rst_n_i(rst_n_i), .sensor_i(sens), .sensor_oe_i(oe), .rotation_i(rotation_i),
    .enable_i(enable_i), .sensor_supply_ref_ok_i(ok_i), .peak_limit_i(peak_i),
    .over_current_i(over_i), .current_error_i(err_i), .drive_o(drive_o), .speed_o(speed_o));
  function automatic logic [5:0] exp_drive(input logic [2:0] c, input logic r);
    logic [5:0] v;
    case (c)
      3'h1: v = 6'h0a;
      3'h2: v = 6'h14;
      3'h3: v = 6'h0c;
      3'h4: v = 6'h21;
      3'h5: v = 6'h22;
      3'h6: v = 6'h11;
      default: v = 6'h00;
    endcase
    // the reverse direction swaps source and sink on every phase
    return r ? v : {v[2:0], v[5:3]};
  endfunction
  task automatic finish_test();
    $display("checks=%0d errors=%0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // pwm gating blanks the drive part of each period, so wait for an on phase
  task automatic wait_drive();
    int n;
    n = 0;
    while (drive_o === 6'h00 && n < 1200) begin
      @(negedge clk_i);
      n++;
    end
    if (n == 1200) begin
      err_total++;
      finish_test();
    end else check({2'h0, drive_o}, {2'h0, exp_drive(seq[idx], rotation_i)});
  endtask
  task automatic hold_zero(input int n);
    logic bad;
    bad = 0;
    repeat (n) begin
      @(negedge clk_i);
      if (drive_o !== 6'h00) bad = 1;
    end
    check({7'h0, bad}, 8'h00);
  endtask
  task automatic step();
    @(posedge clk_i) adv <= 1;
    @(posedge clk_i) adv <= 0;
    idx = (idx == 5) ? 0 : idx + 1;
  endtask
  task automatic t_table();
    repeat (6) begin
      step();
      repeat (5) @(negedge clk_i);
      wait_drive();
    end
    $display("test table done");
  endtask
  task automatic t_speed();
    step();
    repeat (6) @(negedge clk_i);
    check({7'h0, speed_o}, 8'h01);
    repeat (PW - 8) @(negedge clk_i);
    step();
    repeat (14) @(negedge clk_i);
    check({7'h0, speed_o}, 8'h01);
    repeat (PW) @(negedge clk_i);
    check({7'h0, speed_o}, 8'h00);
    $display("test speed done");
  endtask
  task automatic t_gate();
    for (int k = 0; k < 7; k++) begin
      @(posedge clk_i);
      case (k)
        0: enable_i <= 0;
        1: ok_i <= 0;
        2: peak_i <= 1;
        3: over_i <= 1;
        4: err_i <= 8'h00;
        5: flt <= 1;
        default: shrt <= 1;
      endcase
      repeat (4) @(negedge clk_i);
      hold_zero(300);
      @(posedge clk_i);
      {enable_i, ok_i, peak_i, over_i, flt, shrt} <= 6'h30;
      err_i <= 8'hff;
      repeat (4) @(negedge clk_i);
      wait_drive();
    end
    $display("test gate done");
  endtask
  task automatic t_rotation();
    @(posedge clk_i) rotation_i <= ~rotation_i;
    repeat (6) @(negedge clk_i);
    // blanking lasts at least one 256 cycle pwm period
    hold_zero(200);
    wait_drive();
    $display("test rotation done");
  endtask
  initial begin
    {clk_i, rst_n_i, adv, flt, peak_i, over_i, shrt} = 7'h00;
    {rotation_i, enable_i, ok_i} = 3'h7;
    err_i = 8'hff;
    idx = 0;
    repeat (16) @(posedge clk_i);
    check({2'h0, drive_o}, 8'h00);
    rst_n_i <= 1;
    t_table();
    t_speed();
    t_gate();
    t_rotation();
    t_table();
    finish_test();
  end
endmodule // bldc_commutation_logic_tb
